//--- common/mfs_pkg.sv
// Operation
// - Overcurrent fault only after current exceeds limit for more than 2 s.
// - Direction relays switch only with semiconductors off and no load current.
// - Thermal trip switches motor off, latches fault 8 until acknowledged; only while current monitoring is off.
// - Reset, acknowledge or supply loss clear the thermal model state.
// - Missing mains phase during start latches fault 4 until acknowledged.
// - Overcurrent stops semiconductors, drops ready relay, latches the fault.
// - Overcurrent shows code 5; cleared by supply cycle, button or remote.
// - Mains isolating relay open in off state and every fault state.
// - With both requests, first detected runs; other ignored meanwhile.
// - Dropping the active request with opposite held reverses via soft start.
// - Ready relay closed exactly while no fault is latched.
// - Supply indicator steady on while auxiliary supply is present.
// - Clockwise indicator flashes during ramps, steady when bridged.
// - Anticlockwise indicator flashes during ramps, steady when bridged.
// - Error indicator repeats groups of pulses counting the fault number.
// - Start ramps voltage from starting torque over configured start time.
// - Soft stop ramps down from stop torque over deceleration time.
// - Acknowledge held over 2 s restores the fault and is invalid.
// - Anticlockwise mains rotating field is a fault; the code detects it only in the start state.
package mfs_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYC        = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_S          = 2;
	localparam int ACK_HOLD_S    = 2;
	localparam logic [11:0] OC_MS          = 12'(OC_S * 1000);
	localparam logic [11:0] ACK_HOLD_MS    = 12'(ACK_HOLD_S * 1000);
	localparam logic [11:0] SWITCH_MS      = 12'(250);
	localparam logic [11:0] BLINK_MS       = 12'(250);
	localparam logic [11:0] FLASH_ON_MS    = 12'(250);
	localparam logic [11:0] FLASH_OFF_MS   = 12'(250);
	localparam logic [11:0] FLASH_PAUSE_MS = 12'(1500);
	localparam logic [15:0] RAMP_UNIT_MS   = 16'(100);
	localparam logic [7:0]  LVL_FULL       = 8'h64;

	// ---------------------------------------------------------------
	// Register map, byte offsets and fields
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_START  = 4'h4;
	localparam logic [3:0] REG_STOP   = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int CTRL_CW       = 0;
	localparam int CTRL_CCW      = 1;
	localparam int CTRL_ACK      = 2;
	localparam int CTRL_CURMON   = 3;
	localparam int CTRL_SOFTSTOP = 4;
	localparam logic       CURMON_RST     = 1'b1;
	localparam logic       SOFTSTOP_RST   = 1'b1;
	localparam logic [7:0] START_LVL_RST  = 8'h1E;
	localparam logic [7:0] START_TIME_RST = 8'h0A;
	localparam logic [7:0] STOP_LVL_RST   = 8'h32;
	localparam logic [7:0] STOP_TIME_RST  = 8'h0A;

	// ---------------------------------------------------------------
	// Fault codes
	// ---------------------------------------------------------------
	localparam logic [3:0] FLT_NONE     = 4'h0;
	localparam logic [3:0] FLT_OVERTEMP = 4'h1;
	localparam logic [3:0] FLT_FREQ     = 4'h2;
	localparam logic [3:0] FLT_PHSEQ    = 4'h3;
	localparam logic [3:0] FLT_PHLOSS   = 4'h4;
	localparam logic [3:0] FLT_OVERCUR  = 4'h5;
	localparam logic [3:0] FLT_RELAY    = 4'h6;
	localparam logic [3:0] FLT_TEMPCIRC = 4'h7;
	localparam logic [3:0] FLT_THERMAL  = 4'h8;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_OPEN, ST_CLOSE, ST_START, ST_RUN, ST_STOP, ST_FAULT
	} mfs_state_e;

	typedef struct packed {
		logic       auxOk;
		logic [2:0] phasePresent;
		logic       seqCw;
		logic       overCurrent;
		logic       thermalTrip;
		logic       overTemp;
		logic       wrongFreq;
		logic       relayStuck;
		logic       tempCircuit;
	} mfs_sense_s;

	typedef struct packed {
		logic semiOn;
		logic bypass;
		logic dirCw;
		logic dirCcw;
		logic mainsClose;
		logic readyRelay;
		logic thermalClear;
		logic remoteAckOut;
	} mfs_drive_s;

	typedef struct packed {
		logic supply;
		logic cw;
		logic ccw;
	} mfs_led_s;

	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} mfs_avs_req_s;

endpackage : mfs_pkg

//--- design/mfs_flash_code.sv
`timescale 1ns/1ps
module mfs_flash_code
	import mfs_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Timebase and code
	input  wire logic       msTick,
	input  wire logic [3:0] code,
	// Indicator
	output logic            led
);

	typedef struct packed {
		logic       on;
		logic       pause;
		logic [3:0] left;
		logic [11:0] cnt;
	} mfs_flash_s;

	mfs_flash_s st_q, st_d;

	// ---------------------------------------------------------------
	// Pulse group sequencer
	// ---------------------------------------------------------------
	// Group restarts after a long pause so the count reads clearly
	always_comb
	begin
		st_d = st_q;
		if (code == FLT_NONE)
		begin
			st_d = '0;
		end
		else if (msTick)
		begin
			st_d.cnt = st_q.cnt + 12'h001;
			if (st_q.pause)
			begin
				if (st_q.cnt >= FLASH_PAUSE_MS)
				begin
					st_d.pause = 1'b0;
					st_d.on    = 1'b1;
					st_d.left  = code;
					st_d.cnt   = '0;
				end
			end
			else if (st_q.on)
			begin
				if (st_q.cnt >= FLASH_ON_MS)
				begin
					st_d.on   = 1'b0;
					st_d.left = st_q.left - 4'h1;
					st_d.cnt  = '0;
				end
			end
			else if (st_q.cnt >= FLASH_OFF_MS)
			begin
				st_d.cnt = '0;
				if (st_q.left == 4'h0)
					st_d.pause = 1'b1;
				else
					st_d.on = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign led = st_q.on;

endmodule : mfs_flash_code

//--- design/mfs_ramp_gen.sv
`timescale 1ns/1ps
module mfs_ramp_gen
	import mfs_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Control
	input  wire logic       msTick,
	input  wire logic       go,
	input  wire logic       up,
	input  wire logic [7:0] fromLvl,
	input  wire logic [7:0] timeCfg,
	// Result
	output logic [7:0]      level,
	output logic            busy
);

	typedef struct packed {
		logic        up;
		logic        busy;
		logic [7:0]  level;
		logic [7:0]  span;
		logic [15:0] acc;
		logic [15:0] elapsed;
		logic [15:0] total;
	} mfs_ramp_s;

	mfs_ramp_s st_q, st_d;

	// ---------------------------------------------------------------
	// Linear ramp by error accumulation
	// ---------------------------------------------------------------
	// One step per tick at most; for levels up to 100 spans stay below 101 steps, and the
	// shortest nonzero time is 100 ticks, so no step is ever skipped.
	always_comb
	begin
		logic [15:0] sum;
		sum  = st_q.acc + 16'(st_q.span);
		st_d = st_q;
		if (go)
		begin
			st_d.up      = up;
			st_d.level   = fromLvl;
			st_d.span    = up ? (LVL_FULL - fromLvl) : fromLvl;
			st_d.acc     = '0;
			st_d.elapsed = '0;
			st_d.total   = 16'(timeCfg) * RAMP_UNIT_MS;
			st_d.busy    = (timeCfg != 8'h00);
			if (timeCfg == 8'h00)
				st_d.level = up ? LVL_FULL : 8'h00;
		end
		else if (st_q.busy && msTick)
		begin
			st_d.elapsed = st_q.elapsed + 16'h0001;
			st_d.acc     = sum;
			if (sum >= st_q.total)
			begin
				st_d.acc   = sum - st_q.total;
				st_d.level = st_q.up ? st_q.level + 8'h01
				                     : st_q.level - 8'h01;
			end
			if (st_d.elapsed == st_q.total)
			begin
				st_d.busy  = 1'b0;
				st_d.level = st_q.up ? LVL_FULL : 8'h00;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign level = st_q.level;
	assign busy  = st_q.busy;

endmodule : mfs_ramp_gen

//--- design/mfs_supervisor.sv
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module mfs_supervisor
	import mfs_pkg::*;
#(
	parameter int TickCycles = MS_CYC
)
(
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rst,
	// Register bus
	input  wire mfs_avs_req_s  avsReq,
	output logic [31:0]        avsReadData,
	output logic               avsWaitRequest,
	// Run and acknowledge inputs
	input  wire logic          runCw,
	input  wire logic          runCcw,
	input  wire logic          ackButton,
	input  wire logic          remoteAckInput,
	// Measurement and supervision inputs
	input  wire mfs_sense_s    sense,
	// Power stage, relays and indicators
	output mfs_drive_s         drive,
	output logic [7:0]         rampLevel,
	output mfs_led_s           leds,
	output logic               ledErr
);

	typedef struct packed {
		mfs_state_e  state;
		logic        dirCcw;
		logic [11:0] cnt;
		logic [11:0] ocCnt;
		logic [11:0] ackCnt;
		logic        ackPrev;
		logic [3:0]  fault;
		logic [3:0]  saved;
		logic        waitReq;
		logic [31:0] rdata;
		logic        regCw;
		logic        regCcw;
		logic        regAck;
		logic        curMon;
		logic        softStop;
		logic [7:0]  startLvl;
		logic [7:0]  startTime;
		logic [7:0]  stopLvl;
		logic [7:0]  stopTime;
		logic [16:0] div;
		logic        tick;
		logic [11:0] blinkCnt;
		logic        blink;
		logic        rampGo;
		logic        rampUp;
		mfs_drive_s  drv;
		mfs_led_s    led;
	} mfs_sup_s;

	mfs_sup_s    st_q, st_d;
	logic [7:0]  rampLvl;
	logic        rampBusy;
	logic [7:0]  rampFrom;
	logic [7:0]  rampTime;

	// ---------------------------------------------------------------
	// Byte lane merge
	// ---------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
	                                       input logic [31:0] wd,
	                                       input logic [3:0]  be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd & m);
	endfunction : merge

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic        reqCw;
		logic        reqCcw;
		logic        reqAct;
		logic        ackLvl;
		logic        ackEdge;
		logic        active;
		logic [3:0]  newFault;
		logic [31:0] word;
		reqCw    = runCw | st_q.regCw;
		reqCcw   = runCcw | st_q.regCcw;
		reqAct   = st_q.dirCcw ? reqCcw : reqCw;
		ackLvl   = ackButton | remoteAckInput;
		ackEdge  = (ackLvl & ~st_q.ackPrev) | st_q.regAck;
		active   = 1'b0;
		newFault = FLT_NONE;
		word     = '0;
		st_d     = st_q;

		// Millisecond timebase and indicator blink
		st_d.tick = 1'b0;
		st_d.div  = st_q.div + 17'h00001;
		if (st_q.div >= 17'(TickCycles - 1))
		begin
			st_d.div  = '0;
			st_d.tick = 1'b1;
		end
		if (st_q.tick)
		begin
			st_d.blinkCnt = st_q.blinkCnt + 12'h001;
			if (st_q.blinkCnt >= BLINK_MS - 12'h001)
			begin
				st_d.blinkCnt = '0;
				st_d.blink    = ~st_q.blink;
			end
		end

		// Bus slave: one wait cycle, then answer for exactly one edge
		st_d.regAck  = 1'b0;
		st_d.waitReq = 1'b1;
		if ((avsReq.read || avsReq.write) && st_q.waitReq)
		begin
			st_d.waitReq = 1'b0;
			unique case (avsReq.address)
				REG_CTRL:   word = 32'({st_q.softStop, st_q.curMon, 1'b0,
				                        st_q.regCcw, st_q.regCw});
				REG_START:  word = {16'h0000, st_q.startTime, st_q.startLvl};
				REG_STOP:   word = {16'h0000, st_q.stopTime, st_q.stopLvl};
				REG_STATUS: word = {8'h00, rampLvl, 3'h0, st_q.dirCcw,
				                    1'b0, st_q.state, 4'h0, st_q.fault};
				default:    word = '0;
			endcase
			st_d.rdata = word;
		end
		if (avsReq.write && !st_q.waitReq)
		begin
			unique case (avsReq.address)
				REG_CTRL:
				begin
					word = merge(32'({st_q.softStop, st_q.curMon, 1'b0,
					                  st_q.regCcw, st_q.regCw}),
					             avsReq.writedata, avsReq.byteenable);
					st_d.regCw    = word[CTRL_CW];
					st_d.regCcw   = word[CTRL_CCW];
					st_d.regAck   = word[CTRL_ACK] & avsReq.byteenable[0];
					st_d.curMon   = word[CTRL_CURMON];
					st_d.softStop = word[CTRL_SOFTSTOP];
				end
				REG_START:
				begin
					word = merge({16'h0000, st_q.startTime, st_q.startLvl},
					             avsReq.writedata, avsReq.byteenable);
					st_d.startLvl  = word[7:0];
					st_d.startTime = word[15:8];
				end
				REG_STOP:
				begin
					word = merge({16'h0000, st_q.stopTime, st_q.stopLvl},
					             avsReq.writedata, avsReq.byteenable);
					st_d.stopLvl  = word[7:0];
					st_d.stopTime = word[15:8];
				end
				default: ;
			endcase
		end

		// Overcurrent must persist past the limit, not merely reach it
		if (!sense.overCurrent)
			st_d.ocCnt = '0;
		else if (st_q.tick && st_q.ocCnt <= OC_MS)
			st_d.ocCnt = st_q.ocCnt + 12'h001;

		// Acknowledge: clears at press, restored if held too long
		st_d.ackPrev      = ackLvl;
		st_d.rampGo       = 1'b0;
		st_d.drv.thermalClear = 1'b0;
		if (!ackLvl)
		begin
			st_d.ackCnt = '0;
			st_d.saved  = FLT_NONE;
		end
		else if (st_q.tick && st_q.ackCnt <= ACK_HOLD_MS)
			st_d.ackCnt = st_q.ackCnt + 12'h001;
		if (ackEdge)
		begin
			st_d.drv.thermalClear = 1'b1;
			if (st_q.state == ST_FAULT)
			begin
				st_d.saved = ackLvl ? st_q.fault : FLT_NONE;
				st_d.fault = FLT_NONE;
				st_d.state = ST_OPEN;
				st_d.cnt   = '0;
			end
		end
		else if (ackLvl && st_q.ackCnt > ACK_HOLD_MS &&
		         st_q.saved != FLT_NONE)
		begin
			st_d.fault = st_q.saved;
			st_d.saved = FLT_NONE;
			st_d.state = ST_FAULT;
		end

		// Sequencer
		if (st_q.tick)
			st_d.cnt = st_q.cnt + 12'h001;
		unique case (st_q.state)
			ST_IDLE:
			begin
				// Opposite of the last direction wins when both stand after a stop
				if (st_q.saved == FLT_NONE && (reqCw || reqCcw))
				begin
					st_d.dirCcw = (reqCw && reqCcw) ? ~st_q.dirCcw
					                                : reqCcw;
					st_d.state  = ST_CLOSE;
					st_d.cnt    = '0;
				end
			end
			ST_CLOSE:
			begin
				// Relays settle before any semiconductor fires
				if (st_q.cnt >= SWITCH_MS)
				begin
					st_d.state  = ST_START;
					st_d.rampGo = 1'b1;
					st_d.rampUp = 1'b1;
				end
			end
			ST_START:
			begin
				if (!reqAct)
					st_d.state = ST_OPEN;
				else if (!st_q.rampGo && !rampBusy)
					st_d.state = ST_RUN;
				st_d.cnt = '0;
			end
			ST_RUN:
			begin
				if (!reqAct && st_q.softStop)
				begin
					st_d.state  = ST_STOP;
					st_d.rampGo = 1'b1;
					st_d.rampUp = 1'b0;
				end
				else if (!reqAct)
					st_d.state = ST_OPEN;
				st_d.cnt = '0;
			end
			ST_STOP:
			begin
				if (!st_q.rampGo && !rampBusy)
					st_d.state = ST_OPEN;
				st_d.cnt = '0;
			end
			ST_OPEN:
			begin
				// Relays open with the semiconductors; a full delay passes before they can close again
				if (st_q.cnt >= SWITCH_MS)
					st_d.state = ST_IDLE;
			end
			ST_FAULT: ;
		endcase

		// Fault detection; an acknowledge in the fault state wins over a new fault
		if (sense.overTemp)
			newFault = FLT_OVERTEMP;
		else if (sense.wrongFreq)
			newFault = FLT_FREQ;
		else if (st_q.state == ST_START && !sense.seqCw)
			newFault = FLT_PHSEQ;
		else if (st_q.state == ST_START && !(&sense.phasePresent))
			newFault = FLT_PHLOSS;
		else if (st_q.curMon && st_q.ocCnt > OC_MS)
			newFault = FLT_OVERCUR;
		else if (sense.relayStuck)
			newFault = FLT_RELAY;
		else if (sense.tempCircuit)
			newFault = FLT_TEMPCIRC;
		else if (!st_q.curMon && sense.thermalTrip)
			newFault = FLT_THERMAL;
		if (newFault != FLT_NONE && st_q.state != ST_FAULT &&
		    st_q.saved == FLT_NONE)
		begin
			st_d.fault = newFault;
			st_d.state = ST_FAULT;
		end

		// Supply loss is a power cycle: clears state, faults and thermal model
		if (!sense.auxOk)
		begin
			st_d.state  = ST_IDLE;
			st_d.fault  = FLT_NONE;
			st_d.saved  = FLT_NONE;
			st_d.drv.thermalClear = 1'b1;
		end

		// Outputs follow the next state so they leave flops directly
		active = (st_d.state == ST_START) || (st_d.state == ST_RUN) ||
		         (st_d.state == ST_STOP);
		st_d.drv.semiOn     = (st_d.state == ST_START) ||
		                      (st_d.state == ST_STOP);
		st_d.drv.bypass     = (st_d.state == ST_RUN);
		st_d.drv.mainsClose = active || (st_d.state == ST_CLOSE);
		st_d.drv.dirCw      = st_d.drv.mainsClose && !st_d.dirCcw;
		st_d.drv.dirCcw     = st_d.drv.mainsClose && st_d.dirCcw;
		st_d.drv.readyRelay = (st_d.fault == FLT_NONE);
		st_d.drv.remoteAckOut = 1'b1;
		st_d.led.supply     = sense.auxOk;
		st_d.led.cw  = !st_d.dirCcw && ((st_d.state == ST_RUN) ||
		               (st_d.drv.semiOn && st_d.blink));
		st_d.led.ccw = st_d.dirCcw && ((st_d.state == ST_RUN) ||
		               (st_d.drv.semiOn && st_d.blink));
	end

	// ---------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_q           <= '0;
			st_q.state     <= ST_IDLE;
			st_q.curMon    <= CURMON_RST;
			st_q.softStop  <= SOFTSTOP_RST;
			st_q.startLvl  <= START_LVL_RST;
			st_q.startTime <= START_TIME_RST;
			st_q.stopLvl   <= STOP_LVL_RST;
			st_q.stopTime  <= STOP_TIME_RST;
			st_q.waitReq   <= 1'b1;
			st_q.drv.thermalClear <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// ---------------------------------------------------------------
	// Ramp and error code submodules
	// ---------------------------------------------------------------
	assign rampFrom = st_q.rampUp ? st_q.startLvl : st_q.stopLvl;
	assign rampTime = st_q.rampUp ? st_q.startTime : st_q.stopTime;

	mfs_ramp_gen u_ramp (
		.sys_clk (sys_clk),
		.rst     (rst),
		.msTick  (st_q.tick),
		.go      (st_q.rampGo),
		.up      (st_q.rampUp),
		.fromLvl (rampFrom),
		.timeCfg (rampTime),
		.level   (rampLvl),
		.busy    (rampBusy)
	);

	mfs_flash_code u_flash (
		.sys_clk (sys_clk),
		.rst     (rst),
		.msTick  (st_q.tick),
		.code    (st_q.fault),
		.led     (ledErr)
	);

	// ---------------------------------------------------------------
	// Output assignments
	// ---------------------------------------------------------------
	assign avsReadData    = st_q.rdata;
	assign avsWaitRequest = st_q.waitReq;
	assign drive          = st_q.drv;
	assign rampLevel      = rampLvl;
	assign leds           = st_q.led;

endmodule : mfs_supervisor

//--- testbench/mfs_checker.sv
`timescale 1ns/1ps
module mfs_checker
	import mfs_pkg::*;
#(
	parameter int TickCycles = MS_CYC
)
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Watched ports
	input  wire logic       ackButton,
	input  wire mfs_sense_s sense,
	input  wire mfs_drive_s drive,
	input  wire mfs_led_s   leds,
	input  wire logic       ledErr
);
	// ---------------------------------------------------------------
	// Helper logic
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	localparam int OcCyc = 2000 * TickCycles - 2;
	logic [31:0] ocCnt_q;
	logic        quiet;
	// Other trips excluded, so a drop can only be overcurrent
	assign quiet = sense.auxOk && &sense.phasePresent && sense.seqCw
		&& !(|{sense.thermalTrip, sense.overTemp, sense.wrongFreq,
		sense.relayStuck, sense.tempCircuit});
	// Length of the present overcurrent run
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			ocCnt_q <= '0;
		else
			ocCnt_q <= sense.overCurrent ? ocCnt_q + 32'h1 : '0;
	a_fault_isolates:
		assert property (!drive.readyRelay |-> !drive.mainsClose
			&& !drive.semiOn && !drive.bypass)
		else $error("motor live while faulted");
	a_dir_onehot:
		assert property (!(drive.dirCw && drive.dirCcw))
		else $error("both direction relays on");
	a_dir_no_load:
		assert property ($rose(drive.dirCw) || $rose(drive.dirCcw)
			|-> !drive.semiOn && !drive.bypass && !$past(drive.semiOn))
		else $error("direction relay switched under load");
	a_supply_led:
		assert property (!rst |=> leds.supply == $past(sense.auxOk))
		else $error("supply indicator wrong");
	a_cw_steady:
		assert property ((drive.bypass && drive.dirCw) [*3] |-> leds.cw)
		else $error("cw indicator not steady");
	a_ccw_steady:
		assert property ((drive.bypass && drive.dirCcw) [*3] |-> leds.ccw)
		else $error("ccw indicator not steady");
	a_oc_delay:
		assert property ($fell(drive.readyRelay) && $past(quiet)
			&& !$past(ackButton) |-> $past(ocCnt_q) >= OcCyc)
		else $error("overcurrent trip too early");
	a_err_dark:
		assert property (drive.readyRelay [*8] |-> !ledErr)
		else $error("error indicator lit without fault");
	a_thermal_clear:
		assert property (!sense.auxOk [*2] |-> drive.thermalClear)
		else $error("thermal model kept on supply loss");
	// Main scenarios reached
	c_oc_trip: cover property ($fell(drive.readyRelay) && sense.overCurrent);
	c_reverse: cover property ($rose(drive.dirCcw));
	c_bridged: cover property ($rose(drive.bypass));
endmodule : mfs_checker

bind mfs_supervisor mfs_checker #(.TickCycles(TickCycles)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .ackButton(ackButton), .sense(sense),
	.drive(drive), .leds(leds), .ledErr(ledErr));

//--- testbench/mfs_switch_model.sv
`timescale 1ns/1ps
module mfs_switch_model
(
	// Clock
	input  wire logic       sys_clk,
	// Bench command and pace
	input  wire logic [3:0] cmd,
	input  wire logic       slow,
	// Contacts to the starter
	output logic            runCw,
	output logic            runCcw,
	output logic            ackButton,
	output logic            remoteAckInput
);
	// ---------------------------------------------------------------
	// Contact delay line
	// ---------------------------------------------------------------
	logic [3:0] dly_q [4] = '{default: 4'h0};
	// Slow contacts close three cycles after prompt ones
	always_ff @(posedge sys_clk)
	begin
		dly_q[0] <= cmd;
		for (int i = 1; i < 4; i++)
			dly_q[i] <= dly_q[i - 1];
	end
	// Plain levels; a request is dropped to reverse or for an acknowledge
	assign {remoteAckInput, ackButton, runCcw, runCw} =
		slow ? dly_q[3] : dly_q[0];
endmodule : mfs_switch_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb
	import mfs_pkg::*;
;
	// ---------------------------------------------------------------
	// Clock, stimulus and wiring
	// ---------------------------------------------------------------
	localparam int TC = 5;
	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	mfs_avs_req_s req = '0;
	mfs_sense_s   sense = 11'h7C0;
	logic [3:0]   sw = 4'h0;
	logic         slow = 1'b0;
	logic [31:0]  rdata, q;
	logic         runCw, runCcw, ackButton, remoteAckInput;
	logic         avsWaitRequest, ledErr, errPrev;
	mfs_drive_s   drive;
	mfs_led_s     leds;
	logic [7:0]   rampLevel, lvl;
	logic [63:0]  notes [$];
	logic [63:0]  nt;
	int           failures = 0;
	int           n_tests = 0;
	int           seed = 47;
	int           rises = 0;
	int           k;
	initial forever #5 sys_clk = ~sys_clk;
	mfs_switch_model sw_m (.sys_clk(sys_clk), .cmd(sw), .slow(slow),
		.runCw(runCw), .runCcw(runCcw), .ackButton(ackButton),
		.remoteAckInput(remoteAckInput));
	mfs_supervisor #(.TickCycles(TC)) dut (.sys_clk(sys_clk), .rst(rst),
		.avsReq(req), .avsReadData(rdata), .avsWaitRequest(avsWaitRequest),
		.runCw(runCw), .runCcw(runCcw), .ackButton(ackButton),
		.remoteAckInput(remoteAckInput), .sense(sense), .drive(drive),
		.rampLevel(rampLevel), .leds(leds), .ledErr(ledErr));
	// Verdict, reached from the sequence or the watchdog
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Avalon cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		req.address <= a;
		req.writedata <= d;
		req.byteenable <= 4'hF;
		req.write <= w;
		req.read <= !w;
		do
		begin
			@(posedge sys_clk);
		end
		while (avsWaitRequest !== 1'b0);
		q = rdata;
		req.write <= 1'b0;
		req.read <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input logic [31:0] m);
		notes.push_back({e, m});
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic ticks(input int t);
		repeat (t * TC) @(posedge sys_clk);
	endtask : ticks
	// Poll the state field, bounded
	task automatic wst(input logic [2:0] s);
		int n;
		n = 0;
		do
		begin
			bus(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (q[10:8] !== s && n < 5000);
	endtask : wst
	// Ramp indicator must show both levels in 500 ticks
	task automatic blink(input logic d);
		int n;
		n = 0;
		repeat (10)
		begin
			ticks(50);
			n += d ? leds.ccw : leds.cw;
		end
		chk(32'(n > 0 && n < 10), 32'h1);
	endtask : blink
	// Read answers checked against the oldest note
	always @(negedge sys_clk)
		if (req.read && avsWaitRequest === 1'b0 && notes.size() > 0)
		begin
			nt = notes.pop_front();
			chk(rdata & nt[31:0], nt[63:32]);
		end
	// Error indicator pulse counter; sampled before the edge lands
	always @(posedge sys_clk)
	begin
		errPrev <= ledErr;
		if (ledErr === 1'b1 && errPrev === 1'b0)
			rises <= rises + 1;
	end
	// ---------------------------------------------------------------
	// Test sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		rd(REG_CTRL, 32'h18, 32'h1F);
		rd(REG_START, 32'h0A1E, 32'hFFFF);
		rd(REG_STOP, 32'h0A32, 32'hFFFF);
		lvl = 8'h1E + 8'($random(seed) & 32'h1F);
		bus(1'b1, REG_START, {16'h0, 8'h06, lvl});
		rd(REG_START, {16'h0, 8'h06, lvl}, 32'hFFFF);
		bus(1'b1, REG_STOP, 32'h0132);
		bus(1'b1, REG_STATUS, 32'hFFFFFFFF);
		rd(REG_STATUS, 32'h0, 32'h170F);
		$display("test registers done");
		sw <= 4'h1;
		wst(3'h3);
		blink(1'b0);
		wst(3'h4);
		rd(REG_STATUS, 32'h640400, 32'hFF170F);
		chk(32'({drive.bypass, leds.cw, drive.dirCw}), 32'h7);
		chk(32'({drive.remoteAckOut, rampLevel}), 32'h164);
		$display("test clockwise start done");
		slow <= 1'b1;
		sw <= 4'h3;
		ticks(20);
		rd(REG_STATUS, 32'h0400, 32'h170F);
		sw <= 4'h2;
		wst(3'h3);
		blink(1'b1);
		wst(3'h4);
		rd(REG_STATUS, 32'h641400, 32'hFF170F);
		chk(32'({drive.bypass, leds.ccw, drive.dirCcw}), 32'h7);
		$display("test reversal done");
		sense.overCurrent <= 1'b1;
		ticks(1990);
		chk(32'(drive.readyRelay), 32'h1);
		ticks(20);
		chk(32'({drive.readyRelay, drive.mainsClose}), 32'h0);
		rd(REG_STATUS, 32'h0605, 32'h070F);
		sense.overCurrent <= 1'b0;
		ticks(5);
		rd(REG_STATUS, 32'h0605, 32'h070F);
		sw <= 4'h8;
		ticks(1);
		sw <= 4'h0;
		ticks(2);
		rd(REG_STATUS, 32'h0, 32'hF);
		chk(32'(drive.readyRelay), 32'h1);
		$display("test overcurrent done");
		sense.wrongFreq <= 1'b1;
		ticks(1);
		sense.wrongFreq <= 1'b0;
		k = 0;
		while (ledErr !== 1'b1 && k < 30000)
		begin
			@(negedge sys_clk);
			k++;
		end
		rises = 0;
		ticks(2400);
		chk(32'(rises), 32'h2);
		ticks(200);
		chk(32'(rises), 32'h3);
		bus(1'b1, REG_CTRL, 32'h1C);
		rd(REG_STATUS, 32'h0, 32'hF);
		$display("test error code done");
		slow <= 1'b0;
		sense.phasePresent <= 3'h6;
		sw <= 4'h1;
		ticks(600);
		rd(REG_STATUS, 32'h0604, 32'h070F);
		sense.phasePresent <= 3'h7;
		sw <= 4'h0;
		ticks(1);
		sw <= 4'h4;
		ticks(5);
		rd(REG_STATUS, 32'h0, 32'hF);
		ticks(2010);
		rd(REG_STATUS, 32'h0604, 32'h070F);
		sw <= 4'h0;
		ticks(1);
		sw <= 4'h8;
		ticks(1);
		sw <= 4'h0;
		ticks(2);
		rd(REG_STATUS, 32'h0, 32'hF);
		$display("test phase loss done");
		bus(1'b1, REG_CTRL, 32'h10);
		sense.thermalTrip <= 1'b1;
		ticks(1);
		sense.thermalTrip <= 1'b0;
		rd(REG_STATUS, 32'h0608, 32'h070F);
		sw <= 4'h8;
		ticks(1);
		sw <= 4'h0;
		ticks(2);
		rd(REG_STATUS, 32'h0, 32'hF);
		sense.auxOk <= 1'b0;
		ticks(1);
		chk(32'({leds.supply, drive.thermalClear}), 32'h1);
		sense.auxOk <= 1'b1;
		ticks(1);
		chk(32'(leds.supply), 32'h1);
		$display("test thermal and supply done");
		tally_and_finish();
	end
	// Watchdog, well beyond the expected run length
	initial
	begin
		repeat (90000) @(posedge sys_clk);
		failures++;
		tally_and_finish();
	end
endmodule : tb
